// File: hw/pcfd_top.sv
// digital model of a phase-locked clock fanout driver
// assumes: reference and feedback pins are slower than clk_in / 2,
// and software reaches the registers over classic wishbone
//
// Notes on behaviour
// - reference chooser high picks second reference
// - enable-reset low tri-states every clock output
// - enable-reset low clears output registers asynchronously
// - inverted output: primary frequency, opposite polarity
// - doubled output: twice primary, rising edges aligned
// - halved output: half primary, rising edges aligned
// - lock flag high once locked, else low
// - edge select low rising, high falling reference
// - loop enable switches the loop on or off
// - range select low inserts divide-by-two in oscillator
// - eight outputs: five primary, inverted, doubled, halved
// - range select leaves output frequencies unchanged
//
// Added by the designer: the Wishbone interface to the registers and the register addresses.
`include "pcfd_params.svh"
`timescale 1ns/1ns
`default_nettype none
module pcfd_top #(
  parameter int NPRIM = 5,
  parameter logic [15:0] HALF_RST = `PCFD_HALF_RST
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic wb_we_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  output logic irq_out,
  input wire logic ref_clk_a_in,
  input wire logic ref_clk_b_in,
  input wire logic ref_sel_in,
  input wire logic osc_range_select_in,
  input wire logic sync_edge_select_in,
  input wire logic loop_enable_in,
  input wire logic feedback_in,
  input wire logic out_enable_rst_n_in,
  output logic [NPRIM-1:0] primary_clock_outputs_out,
  output logic [NPRIM-1:0] primary_clock_oe_n_out,
  output logic inverted_clock_output_out,
  output logic inverted_clock_oe_n_out,
  output logic doubled_clock_output_out,
  output logic doubled_clock_oe_n_out,
  output logic halved_clock_output_out,
  output logic halved_clock_oe_n_out,
  output logic lock_out
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  pcfd_pin_if pin_if [`PCFD_NPIN] ();
  logic [`PCFD_NPIN-1:0] pin_raw;
  logic [`PCFD_NPIN-1:0] pin_lvl;
  logic [`PCFD_NPIN-1:0] pin_rise;
  logic [`PCFD_NPIN-1:0] pin_fall;

  assign pin_raw[`PCFD_PIN_REFA] = ref_clk_a_in;
  assign pin_raw[`PCFD_PIN_REFB] = ref_clk_b_in;
  assign pin_raw[`PCFD_PIN_FB] = feedback_in;
  assign pin_raw[`PCFD_PIN_RSEL] = ref_sel_in;
  assign pin_raw[`PCFD_PIN_RANGE] = osc_range_select_in;
  assign pin_raw[`PCFD_PIN_EDGE] = sync_edge_select_in;
  assign pin_raw[`PCFD_PIN_LOOP] = loop_enable_in;

  // one synchroniser per pin
  for (genvar p = 0; p < `PCFD_NPIN; p++) begin : g_pin
    pcfd_pin_sync u_sync (
      .clk_in(clk_in),
      .arst_n_in(arst_n_in),
      .pin_in(pin_raw[p]),
      .pin(pin_if[p])
    );
    assign pin_lvl[p] = pin_if[p].lvl;
    assign pin_rise[p] = pin_if[p].rise;
    assign pin_fall[p] = pin_if[p].fall;
  end

  // ****************************************************************
  // reference choice and edge selection
  // ****************************************************************
  wire logic use_b = pin_lvl[`PCFD_PIN_RSEL];
  wire logic use_fall = pin_lvl[`PCFD_PIN_EDGE];
  wire logic loop_on = pin_lvl[`PCFD_PIN_LOOP];
  wire logic range_hi = pin_lvl[`PCFD_PIN_RANGE];
  // second reference when chooser is high
  wire logic ref_rise = use_b ? pin_rise[`PCFD_PIN_REFB]
                              : pin_rise[`PCFD_PIN_REFA];
  wire logic ref_fall = use_b ? pin_fall[`PCFD_PIN_REFB]
                              : pin_fall[`PCFD_PIN_REFA];
  // feedback compared on the same polarity as the reference
  wire logic ref_edge = use_fall ? ref_fall : ref_rise;
  wire logic fb_edge = use_fall ? pin_fall[`PCFD_PIN_FB]
                                : pin_rise[`PCFD_PIN_FB];

  // ****************************************************************
  // oscillator model and range divider
  // ****************************************************************
  logic [15:0] osc_cnt_reg;
  logic [15:0] half_reg;
  logic [15:0] half_next;
  logic rdiv_reg;

  wire logic osc_tick = loop_on && (osc_cnt_reg >= half_reg - 16'h0001);
  // range low inserts a divide-by-two, so the oscillator runs twice
  // as fast and the loop halves its period: outputs stay put
  wire logic vco_tick = range_hi ? osc_tick
                                 : (osc_tick & rdiv_reg);
  // loop off: chain steps straight on the chosen reference edge
  wire logic chain_tick = loop_on ? vco_tick : ref_edge;

  // oscillator counter and range divider
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      osc_cnt_reg <= 16'h0000;
      rdiv_reg <= 1'b0;
    end else begin
      osc_cnt_reg <= (osc_tick || !loop_on) ? 16'h0000
                                            : osc_cnt_reg + 16'h0001;
      rdiv_reg <= loop_on ? (rdiv_reg ^ osc_tick) : 1'b0;
    end
  end

  // ****************************************************************
  // phase/frequency tracking
  // ****************************************************************
  logic [1:0] fbn_reg;
  logic [7:0] good_reg;
  logic [7:0] good_next;
  logic [7:0] ctrl_thr_reg;
  pcfd_pkg::pcfd_loop_t state_reg;
  pcfd_pkg::pcfd_loop_t state_next;

  // feedback edges seen since the last reference edge, saturating
  wire logic [1:0] fbn_inc = (fbn_reg == 2'h3) ? fbn_reg
                                               : fbn_reg + 2'h1;
  wire logic fb_slow = (fbn_reg == 2'h0);
  wire logic fb_fast = (fbn_reg >= 2'h2);
  wire logic fb_match = (fbn_reg == 2'h1);
  wire logic [7:0] good_inc = (good_reg == 8'hFF) ? good_reg
                                                  : good_reg + 8'h01;
  wire logic thr_met = (good_inc >= ctrl_thr_reg);

  // ratio is set by whichever output the board returns on feedback
  // so the loop only counts feedback edges per reference period
  always_comb begin
    half_next = half_reg;
    if (loop_on && ref_edge && fb_slow && half_reg > 16'h0001) begin
      half_next = half_reg - 16'h0001;
    end else if (loop_on && ref_edge && fb_fast &&
                 half_reg != `PCFD_HALF_MAX) begin
      half_next = half_reg + 16'h0001;
    end
  end

  // lock state; locked after ctrl_thr_reg matching periods in a row, at least one
  always_comb begin
    state_next = state_reg;
    good_next = good_reg;
    case (state_reg)
      pcfd_pkg::loop_bypass: begin
        good_next = 8'h00;
        if (loop_on) begin
          state_next = pcfd_pkg::loop_acquire;
        end
      end
      pcfd_pkg::loop_acquire: begin
        if (ref_edge) begin
          good_next = fb_match ? good_inc : 8'h00;
          if (fb_match && thr_met) begin
            state_next = pcfd_pkg::loop_locked;
          end
        end
      end
      pcfd_pkg::loop_locked: begin
        if (ref_edge && !fb_match) begin
          state_next = pcfd_pkg::loop_acquire;
          good_next = 8'h00;
        end
      end
      default: begin
        state_next = pcfd_pkg::loop_bypass;
      end
    endcase
    if (!loop_on) begin
      state_next = pcfd_pkg::loop_bypass;
      good_next = 8'h00;
    end
  end

  // tracking registers
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      fbn_reg <= 2'h0;
      half_reg <= HALF_RST;
      good_reg <= 8'h00;
      state_reg <= pcfd_pkg::loop_bypass;
    end else begin
      fbn_reg <= ref_edge ? {1'b0, fb_edge}
                          : (fb_edge ? fbn_inc : fbn_reg);
      half_reg <= half_next;
      good_reg <= good_next;
      state_reg <= state_next;
    end
  end

  wire logic lock_now = (state_reg == pcfd_pkg::loop_locked);
  wire logic lock_new = (state_next == pcfd_pkg::loop_locked);
  wire logic ev_gain = lock_new & ~lock_now;
  wire logic ev_lost = lock_now & ~lock_new;

  // ****************************************************************
  // output divider chain, cleared by enable-reset or system reset
  // ****************************************************************
  // the enable-reset pin acts without the clock, so it joins the
  // async reset directly rather than through a synchroniser
  wire logic out_clr_n = arst_n_in & out_enable_rst_n_in;
  logic [2:0] chain_reg;
  logic [NPRIM-1:0] prim_reg;
  logic inv_reg;
  logic dbl_reg;
  logic half_out_reg;
  logic [7:0] oe_n_reg;

  // primary, doubled and halved rise on falling chain bits; a carry through all
  // three bits makes those three outputs rise on the same clock edge as inverted falls
  wire logic [2:0] chain_next = chain_tick ? chain_reg + 3'h1
                                           : chain_reg;

  // chain and clock output flops
  always_ff @(posedge clk_in or negedge out_clr_n) begin
    if (!out_clr_n) begin
      chain_reg <= 3'h7;
      dbl_reg <= 1'b0;
      inv_reg <= 1'b0;
      half_out_reg <= 1'b0;
      oe_n_reg <= 8'hFF;
    end else begin
      chain_reg <= chain_next;
      dbl_reg <= ~chain_next[0];
      inv_reg <= chain_next[1];
      half_out_reg <= ~chain_next[2];
      oe_n_reg <= 8'h00;
    end
  end

  // five matched primary copies, one flop each
  for (genvar q = 0; q < NPRIM; q++) begin : g_prim
    always_ff @(posedge clk_in or negedge out_clr_n) begin
      if (!out_clr_n) begin
        prim_reg[q] <= 1'b0;
      end else begin
        prim_reg[q] <= ~chain_next[1];
      end
    end
  end

  assign primary_clock_outputs_out = prim_reg;
  assign primary_clock_oe_n_out = {NPRIM{oe_n_reg[0]}};
  assign inverted_clock_output_out = inv_reg;
  assign inverted_clock_oe_n_out = oe_n_reg[5];
  assign doubled_clock_output_out = dbl_reg;
  assign doubled_clock_oe_n_out = oe_n_reg[6];
  assign halved_clock_output_out = half_out_reg;
  assign halved_clock_oe_n_out = oe_n_reg[7];

  // ****************************************************************
  // wishbone slave, status and interrupts
  // ****************************************************************
  logic ack_reg;
  logic [31:0] dat_reg;
  logic [`PCFD_IRQ_W-1:0] irq_stat_reg;
  logic [`PCFD_IRQ_W-1:0] irq_mask_reg;
  logic irq_reg;
  logic lock_reg;
  logic [31:0] rd_mux;

  wire logic bus_req = wb_cyc_in & wb_stb_in & ~ack_reg;
  wire logic bus_wr = bus_req & wb_we_in & wb_sel_in[0];
  wire logic hit_ctrl = (wb_adr_in == `PCFD_ADDR_CTRL);
  wire logic hit_stat = (wb_adr_in == `PCFD_ADDR_STATUS);
  wire logic hit_istat = (wb_adr_in == `PCFD_ADDR_IRQ_STAT);
  wire logic hit_imask = (wb_adr_in == `PCFD_ADDR_IRQ_MASK);
  wire logic [`PCFD_IRQ_W-1:0] ev_vec = {ev_lost, ev_gain};
  wire logic [`PCFD_IRQ_W-1:0] w1c =
    (bus_wr && hit_istat) ? wb_dat_in[`PCFD_IRQ_W-1:0]
                          : {`PCFD_IRQ_W{1'b0}};
  // a new event wins over a clear in the same cycle
  wire logic [`PCFD_IRQ_W-1:0] istat_next =
    (irq_stat_reg & ~w1c) | ev_vec;
  wire logic [`PCFD_IRQ_W-1:0] imask_next =
    (bus_wr && hit_imask) ? wb_dat_in[`PCFD_IRQ_W-1:0] : irq_mask_reg;

  // read selection; unmapped offsets read zero and still ack
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_mux[`PCFD_CTRL_THR_MSB:`PCFD_CTRL_THR_LSB] = ctrl_thr_reg;
    end else if (hit_stat) begin
      rd_mux[`PCFD_ST_LOCK] = lock_reg;
      rd_mux[`PCFD_ST_LOOP] = loop_on;
      rd_mux[`PCFD_ST_REFB] = use_b;
      rd_mux[`PCFD_ST_FALL] = use_fall;
      rd_mux[`PCFD_ST_HALF_MSB:`PCFD_ST_HALF_LSB] = half_reg;
    end else if (hit_istat) begin
      rd_mux[`PCFD_IRQ_W-1:0] = irq_stat_reg;
    end else if (hit_imask) begin
      rd_mux[`PCFD_IRQ_W-1:0] = irq_mask_reg;
    end
  end

  // bus, control and interrupt registers
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
      ctrl_thr_reg <= `PCFD_CTRL_RST;
      irq_stat_reg <= {`PCFD_IRQ_W{1'b0}};
      irq_mask_reg <= {`PCFD_IRQ_W{1'b0}};
      irq_reg <= 1'b0;
      lock_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req;
      dat_reg <= bus_req ? rd_mux : 32'h0000_0000;
      if (bus_wr && hit_ctrl) begin
        ctrl_thr_reg <= wb_dat_in[`PCFD_CTRL_THR_MSB:`PCFD_CTRL_THR_LSB];
      end
      irq_stat_reg <= istat_next;
      irq_mask_reg <= imask_next;
      irq_reg <= |(istat_next & imask_next);
      lock_reg <= lock_new;
    end
  end

  assign wb_ack_out = ack_reg;
  assign wb_dat_out = dat_reg;
  assign irq_out = irq_reg;
  assign lock_out = lock_reg;

endmodule : pcfd_top
`default_nettype wire

// File: hw/pcfd_params.svh
// register offsets, field positions, reset values and pin indices
// assumes: included by bare name from every file that needs a constant
`ifndef PCFD_PARAMS_SVH
`define PCFD_PARAMS_SVH

// ****************************************************************
// register map, byte offsets on the wishbone bus
// ****************************************************************
`define PCFD_ADDR_CTRL 8'h00
`define PCFD_ADDR_STATUS 8'h04
`define PCFD_ADDR_IRQ_STAT 8'h08
`define PCFD_ADDR_IRQ_MASK 8'h0C

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define PCFD_CTRL_THR_MSB 7
`define PCFD_CTRL_THR_LSB 0
`define PCFD_CTRL_RST 8'h04
`define PCFD_ST_LOCK 0
`define PCFD_ST_LOOP 1
`define PCFD_ST_REFB 2
`define PCFD_ST_FALL 3
`define PCFD_ST_HALF_LSB 8
`define PCFD_ST_HALF_MSB 23
`define PCFD_IRQ_GAIN 0
`define PCFD_IRQ_LOST 1
`define PCFD_IRQ_W 2
`define PCFD_HALF_RST 16'h0004
`define PCFD_HALF_MAX 16'hFFFF

// ****************************************************************
// synchronised pin indices
// ****************************************************************
`define PCFD_NPIN 7
`define PCFD_PIN_REFA 0
`define PCFD_PIN_REFB 1
`define PCFD_PIN_FB 2
`define PCFD_PIN_RSEL 3
`define PCFD_PIN_RANGE 4
`define PCFD_PIN_EDGE 5
`define PCFD_PIN_LOOP 6

`endif

// File: hw/pcfd_pkg.sv
// types shared by the clock fanout driver files
// assumes: nothing beyond a systemverilog compiler
package pcfd_pkg;
  // loop tracking state
  typedef enum logic [1:0] {
    loop_bypass,
    loop_acquire,
    loop_locked
  } pcfd_loop_t;
endpackage : pcfd_pkg

// File: hw/pcfd_pin_if.sv
// carrier for one synchronised pin: level and both edge pulses
// assumes: driven by pcfd_pin_sync, read by pcfd_top
`timescale 1ns/1ns
`default_nettype none
interface pcfd_pin_if;
  logic lvl;
  logic rise;
  logic fall;
  modport src (output lvl, output rise, output fall);
  modport dst (input lvl, input rise, input fall);
endinterface : pcfd_pin_if
`default_nettype wire

// File: hw/pcfd_pin_sync.sv
// two-flop synchroniser with edge detection for one pin
// assumes: pin is asynchronous to clk_in
`timescale 1ns/1ns
`default_nettype none
module pcfd_pin_sync (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic pin_in,
  pcfd_pin_if.src pin
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  // meta_reg feeds sync_reg only, never any logic
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  // edges from the settled level only
  assign pin.lvl = sync_reg;
  assign pin.rise = sync_reg & ~last_reg;
  assign pin.fall = ~sync_reg & last_reg;
endmodule : pcfd_pin_sync
`default_nettype wire

// File: testbench/pcfd_ref_model.sv
// reference clock sources and board feedback wiring
// assumes: bench sets run and feedback choice; 320 ns period
`timescale 1ns/1ns
`default_nettype none
module pcfd_ref_model #(
  parameter int HI_NS = 80
) (
  input wire logic run_a_in,
  input wire logic run_b_in,
  input wire logic [1:0] fb_sel_in,
  input wire logic prim_in,
  input wire logic dbl_in,
  input wire logic half_in,
  output logic ref_a_out,
  output logic ref_b_out,
  output logic fb_out
);
  // 25 percent duty, so the two edges are far apart in time
  // one fixed rate keeps every output inside its allowed band
  initial begin
    ref_a_out = 1'b0;
    forever begin
      #(320 - HI_NS) ref_a_out = run_a_in;
      #(HI_NS) ref_a_out = 1'b0;
    end
  end
  // second source offset in phase; a stopped source parks low
  initial begin
    ref_b_out = 1'b0;
    #7;
    forever begin
      #(320 - HI_NS) ref_b_out = run_b_in;
      #(HI_NS) ref_b_out = 1'b0;
    end
  end
  // board wire from one chosen output back to the loop
  assign fb_out = (fb_sel_in == 2'h0) ? prim_in :
    (fb_sel_in == 2'h1) ? dbl_in : half_in;
endmodule : pcfd_ref_model
`default_nettype wire

// File: testbench/pcfd_checker.sv
// timing relations on the clock fanout driver ports
// assumes: bound into pcfd_top, inputs changed after clk_in edges
`timescale 1ns/1ns
`default_nettype none
module pcfd_checker #(
  parameter int NPRIM = 5
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_ack_out,
  input wire logic loop_enable_in,
  input wire logic out_enable_rst_n_in,
  input wire logic [NPRIM-1:0] primary_clock_outputs_out,
  input wire logic [NPRIM-1:0] primary_clock_oe_n_out,
  input wire logic inverted_clock_output_out,
  input wire logic inverted_clock_oe_n_out,
  input wire logic doubled_clock_output_out,
  input wire logic doubled_clock_oe_n_out,
  input wire logic halved_clock_output_out,
  input wire logic halved_clock_oe_n_out,
  input wire logic lock_out
);
  // ****************************************************************
  // short names
  // ****************************************************************
  wire logic en = out_enable_rst_n_in;
  wire logic p0 = primary_clock_outputs_out[0];
  wire logic [3:0] oe_n = {inverted_clock_oe_n_out,
    doubled_clock_oe_n_out, halved_clock_oe_n_out,
    &primary_clock_oe_n_out};
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  // chain steps only count while the enable was high on both samples
  a_oe_off_tristate: assert property (
    !en |-> oe_n == 4'hF && primary_clock_outputs_out == '0
    && !doubled_clock_output_out && !halved_clock_output_out
    && !inverted_clock_output_out)
    else $error("outputs not parked while enable low");
  a_oe_on_drive: assert property (
    en [*3] |-> oe_n == 4'h0 && primary_clock_oe_n_out == '0)
    else $error("outputs not driven while enable high");
  a_inv_opposite: assert property (
    en && $past(en) && $changed(p0) |-> inverted_clock_output_out != p0)
    else $error("inverted output not opposite to primary");
  a_prim_all_equal: assert property (
    primary_clock_outputs_out == {NPRIM{p0}})
    else $error("primary outputs differ");
  a_dbl_rise_align: assert property (
    en && $past(en) && $changed(p0) |-> $rose(doubled_clock_output_out))
    else $error("primary change without doubled rise");
  a_half_rise_align: assert property (
    en && $past(en) && $changed(halved_clock_output_out) |-> $rose(p0))
    else $error("halved change without primary rise");
  a_lock_loop_off: assert property (
    !loop_enable_in [*8] |-> !lock_out)
    else $error("lock high with loop off");
  a_ack_one_pulse: assert property (
    wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  a_ack_answer_next: assert property (
    wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("no ack one cycle after request");
endmodule : pcfd_checker
bind pcfd_top pcfd_checker #(.NPRIM(NPRIM)) i_pcfd_checker (.clk_in,
  .arst_n_in, .wb_cyc_in, .wb_stb_in, .wb_ack_out, .loop_enable_in,
  .out_enable_rst_n_in, .primary_clock_outputs_out,
  .primary_clock_oe_n_out, .inverted_clock_output_out,
  .inverted_clock_oe_n_out, .doubled_clock_output_out,
  .doubled_clock_oe_n_out, .halved_clock_output_out,
  .halved_clock_oe_n_out, .lock_out);
`default_nettype wire

// File: testbench/pll_clock_fanout_driver_test.sv
// self-checking bench for the clock fanout driver
// assumes: reference model drives the clock pins at 320 ns
`timescale 1ns/1ns
`default_nettype none
`include "pcfd_params.svh"
module pll_clock_fanout_driver_test;
  logic clk_in = 1'b0, arst_n_in = 1'b0, wb_we_in = 1'b0;
  logic wb_cyc_in = 1'b0, wb_stb_in = 1'b0, ref_sel_in = 1'b0;
  logic osc_range_select_in = 1'b0, sync_edge_select_in = 1'b0;
  logic loop_enable_in = 1'b0, out_enable_rst_n_in = 1'b1;
  logic run_a = 1'b1, run_b = 1'b0;
  logic [1:0] fb_sel = 2'h0;
  logic [7:0] wb_adr_in = 8'h00;
  logic [31:0] wb_dat_in = 32'h0, wb_dat_out, q;
  logic wb_ack_out, irq_out, ref_clk_a_in, ref_clk_b_in, feedback_in;
  logic [4:0] primary_clock_outputs_out, primary_clock_oe_n_out;
  logic inverted_clock_output_out, inverted_clock_oe_n_out;
  logic doubled_clock_output_out, doubled_clock_oe_n_out;
  logic halved_clock_output_out, halved_clock_oe_n_out, lock_out;
  int fails = 0, n_tests = 0, cnt[4];
  realtime t_rise, t_fall;
  pcfd_top i_pcfd_top (.clk_in, .arst_n_in, .wb_adr_in, .wb_dat_in,
    .wb_sel_in(4'hF), .wb_we_in, .wb_cyc_in, .wb_stb_in, .wb_dat_out,
    .wb_ack_out, .irq_out, .ref_clk_a_in, .ref_clk_b_in, .ref_sel_in,
    .osc_range_select_in, .sync_edge_select_in, .loop_enable_in,
    .feedback_in, .out_enable_rst_n_in, .primary_clock_outputs_out,
    .primary_clock_oe_n_out, .inverted_clock_output_out,
    .inverted_clock_oe_n_out, .doubled_clock_output_out,
    .doubled_clock_oe_n_out, .halved_clock_output_out,
    .halved_clock_oe_n_out, .lock_out);
  pcfd_ref_model i_pcfd_ref_model (.run_a_in(run_a), .run_b_in(run_b),
    .fb_sel_in(fb_sel), .prim_in(primary_clock_outputs_out[0]),
    .dbl_in(doubled_clock_output_out), .half_in(halved_clock_output_out),
    .ref_a_out(ref_clk_a_in), .ref_b_out(ref_clk_b_in),
    .fb_out(feedback_in));
  // ****************************************************************
  // clock, edge clocks and shared tasks
  // ****************************************************************
  always #20 clk_in = ~clk_in;
  always @(posedge ref_clk_a_in) t_rise = $realtime;
  always @(negedge ref_clk_a_in) t_fall = $realtime;
  task automatic check(input string s, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", s, exp, seen);
    end
  endtask : check
  // classic single cycle; the bench timeout is the only limit
  task automatic wb(input logic [7:0] a, input logic w,
    input logic [31:0] d);
    @(posedge clk_in);
    wb_adr_in <= a;
    wb_we_in <= w;
    wb_dat_in <= d;
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    do @(posedge clk_in); while (wb_ack_out !== 1'b1);
    q = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] m, e,
    input string s);
    wb(a, 1'b0, 32'h0);
    check(s, q & m, e);
  endtask : rd
  task automatic settle(input int n);
    repeat (n) @(posedge clk_in);
  endtask : settle
  // rising edges of primary, doubled, halved, reference a
  task automatic count(input int n);
    logic [3:0] now, prev;
    cnt = '{0, 0, 0, 0};
    prev = 4'h0;
    for (int k = 0; k <= n; k++) begin
      @(posedge clk_in);
      now = {ref_clk_a_in, halved_clock_output_out,
        doubled_clock_output_out, primary_clock_outputs_out[0]};
      for (int i = 0; i < 4; i++) cnt[i] += (k > 0) && now[i] && !prev[i];
      prev = now;
    end
  endtask : count
  task automatic wait_lock(input logic v, input int n);
    repeat (n) begin
      @(posedge clk_in);
      if (lock_out === v) return;
    end
  endtask : wait_lock
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic test_regs;
    rd(`PCFD_ADDR_CTRL, 32'hFF, `PCFD_CTRL_RST, "ctrl reset");
    rd(`PCFD_ADDR_IRQ_MASK, 32'h3, 32'h0, "mask reset");
    wb(8'h10, 1'b1, 32'hFF);
    rd(8'h10, 32'hFFFFFFFF, 32'h0, "unmapped read");
    wb(`PCFD_ADDR_CTRL, 1'b1, 32'h3);
    rd(`PCFD_ADDR_CTRL, 32'hFF, 32'h3, "ctrl write");
    $display("test_regs done");
  endtask : test_regs
  // loop off: one chain step per chosen reference edge
  task automatic test_bypass;
    settle(20);
    count(512);
    check("ref rises", cnt[3], 64);
    check("dbl rises", cnt[1], 32);
    check("prim rises", cnt[0], 16);
    check("half rises", cnt[2], 8);
    check("lock off", lock_out, 1'b0);
    ref_sel_in <= 1'b1;
    settle(20);
    rd(`PCFD_ADDR_STATUS, 32'h4, 32'h4, "status ref b");
    count(256);
    check("stopped ref b", cnt[1], 0);
    run_b = 1'b1;
    settle(20);
    count(256);
    check("running ref b", cnt[1], 16);
    ref_sel_in <= 1'b0;
    $display("test_bypass done");
  endtask : test_bypass
  // age of the chosen edge when the doubled output steps
  task automatic test_edge;
    logic d0;
    realtime age;
    for (int e = 0; e < 2; e++) begin
      sync_edge_select_in <= e[0];
      settle(30);
      rd(`PCFD_ADDR_STATUS, 32'h8, {e[0], 3'h0}, "status edge");
      d0 = doubled_clock_output_out;
      repeat (40) begin
        @(posedge clk_in);
        #1;
        if (doubled_clock_output_out !== d0) break;
      end
      age = $realtime - (e ? t_fall : t_rise);
      // two sync flops then the chain flop: 80 to 120 ns after the edge
      check("edge age", age >= 81 && age <= 121, 1'b1);
    end
    sync_edge_select_in <= 1'b0;
    $display("test_edge done");
  endtask : test_edge
  task automatic test_oe;
    @(posedge clk_in);
    out_enable_rst_n_in <= 1'b0;
    #1;
    check("oe_n off", {primary_clock_oe_n_out, inverted_clock_oe_n_out,
      doubled_clock_oe_n_out, halved_clock_oe_n_out}, 8'hFF);
    check("outs clear", {primary_clock_outputs_out, inverted_clock_output_out,
      doubled_clock_output_out, halved_clock_output_out}, 8'h00);
    settle(40);
    out_enable_rst_n_in <= 1'b1;
    settle(3);
    check("oe_n on", primary_clock_oe_n_out, 5'h00);
    $display("test_oe done");
  endtask : test_oe
  task automatic test_lock;
    wb(`PCFD_ADDR_IRQ_MASK, 1'b1, 32'h3);
    wb(`PCFD_ADDR_IRQ_STAT, 1'b1, 32'h3);
    loop_enable_in <= 1'b1;
    // lock is only trusted once the oscillator runs in band
    wait_lock(1'b1, 8000);
    check("lock gained", lock_out, 1'b1);
    rd(`PCFD_ADDR_STATUS, 32'h3, 32'h3, "status lock");
    check("irq gain", irq_out, 1'b1);
    osc_range_select_in <= 1'b1;
    wait_lock(1'b1, 8000);
    settle(400);
    count(512);
    check("prim follows ref", cnt[0] >= 63 && cnt[0] <= 65, 1'b1);
    fb_sel = 2'h1;
    wait_lock(1'b0, 400);
    check("lock lost", lock_out, 1'b0);
    loop_enable_in <= 1'b0;
    settle(20);
    rd(`PCFD_ADDR_IRQ_STAT, 32'h3, 32'h3, "gain and loss");
    wb(`PCFD_ADDR_IRQ_MASK, 1'b1, 32'h0);
    settle(2);
    check("irq masked", irq_out, 1'b0);
    wb(`PCFD_ADDR_IRQ_MASK, 1'b1, 32'h2);
    settle(2);
    check("irq unmasked", irq_out, 1'b1);
    wb(`PCFD_ADDR_IRQ_STAT, 1'b1, 32'h3);
    settle(2);
    check("irq cleared", irq_out, 1'b0);
    rd(`PCFD_ADDR_IRQ_STAT, 32'h3, 32'h0, "stat cleared");
    fb_sel = 2'h0;
    $display("test_lock done");
  endtask : test_lock
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict
  // watchdog: 60000 cycles; tests take a few thousand
  initial begin
    #(40 * 60000);
    fails++;
    give_verdict();
  end
  initial begin
    settle(6);
    arst_n_in <= 1'b1;
    test_regs();
    test_bypass();
    test_edge();
    test_oe();
    test_lock();
    give_verdict();
  end
endmodule : pll_clock_fanout_driver_test
`default_nettype wire
